// ==== fram_pkg.sv ====
// constants shared by the serial memory slave and its write buffer
// assumes nothing beyond a SystemVerilog compiler
package fram_pkg;
   localparam int BYTE_BITS = 8;
   localparam int WORD_W = 8;
   localparam int ADDR_W = 9;
   localparam int MEM_DEPTH = 512;
   localparam int FIFO_DEPTH = 16;
   localparam int TYPE_HI = 7;
   localparam int TYPE_LO = 4;
   localparam int SEL_HI = 3;
   localparam int SEL_LO = 2;
   localparam int PAGE_BIT = 1;
   localparam int RW_BIT = 0;
   localparam logic [3:0] BIT_LAST = 4'h7;
   localparam logic [3:0] BIT_FULL = 4'h8;
   localparam logic [3:0] BIT_ZERO = 4'h0;
   localparam logic [3:0] BIT_ONE = 4'h1;
   localparam logic [ADDR_W-1:0] ADDR_ONE = 9'h001;
   localparam logic [ADDR_W-1:0] ADDR_TOP = 9'h1ff;
   localparam logic [ADDR_W-1:0] ADDR_RST = 9'h000;
   localparam logic [WORD_W-1:0] BYTE_RST = 8'h00;

   typedef enum logic [2:0] {P_IDLE, P_RX, P_ACK, P_TX, P_RACK} phase_t;
   typedef enum logic [1:0] {K_SLAVE, K_WORD, K_DATA} kind_t;
endpackage

// ==== wr_fifo.sv ====
// synchronous fifo holding address and data of bytes waiting for the array
// assumes one clock, synchronous active low reset and a clock enable
module wr_fifo
   import fram_pkg::*;
#(
   parameter int WIDTH = ADDR_W + WORD_W,
   parameter int DEPTH = FIFO_DEPTH
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic ce,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int PW = $clog2(DEPTH);

   typedef struct packed {
      logic [PW:0] wr_ptr;
      logic [PW:0] rd_ptr;
   } fifo_state_t;

   fifo_state_t state_ff;
   fifo_state_t nxt_state;
   logic [WIDTH-1:0] store_ff [DEPTH];
   logic push;
   logic pop;

   // full when pointers differ only in the wrap bit
   assign in_ready = !((state_ff.wr_ptr[PW] != state_ff.rd_ptr[PW]) &&
                       (state_ff.wr_ptr[PW-1:0] == state_ff.rd_ptr[PW-1:0]));
   assign out_valid = (state_ff.wr_ptr != state_ff.rd_ptr);
   assign out_data = store_ff[state_ff.rd_ptr[PW-1:0]];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_comb begin
      nxt_state = state_ff;
      if (push) begin
         nxt_state.wr_ptr = state_ff.wr_ptr + 1'b1;
      end
      if (pop) begin
         nxt_state.rd_ptr = state_ff.rd_ptr + 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         state_ff <= '0;
      end else if (ce) begin
         state_ff <= nxt_state;
      end
   end

   always_ff @(posedge clk) begin
      if (ce && push) begin
         store_ff[state_ff.wr_ptr[PW-1:0]] <= in_data;
      end
   end

   fifo_count_a: assert property (@(posedge clk) disable iff (!rstn)
      (state_ff.wr_ptr - state_ff.rd_ptr) <= (PW+1)'(DEPTH))
      else $error("fifo holds more than its depth");
endmodule

// ==== fram_slave.sv ====
// two-wire slave front end and 512 byte array of a serial memory
// assumes the master drives the clock line and an external pull-up on data
module fram_slave
   import fram_pkg::*;
#(
   parameter logic [3:0] DEVICE_TYPE = 4'h5, // arbitrary value
   parameter int DEPTH = FIFO_DEPTH
) (
   input wire logic REF_CLK,
   input wire logic RSTN,
   input wire logic CE,
   input wire logic SCL_IN,
   input wire logic SDA_IN,
   output logic SDA_OUT,
   output logic SDA_OE,
   input wire logic WP,
   input wire logic [1:0] DEVICE_SELECT_PINS
);
   typedef struct packed {
      logic scl_s1;
      logic scl_s2;
      logic scl_d;
      logic sda_s1;
      logic sda_s2;
      logic sda_d;
      logic wp_s1;
      logic wp_s2;
      logic [1:0] sel_s1;
      logic [1:0] sel_s2;
      phase_t phase;
      kind_t kind;
      logic [3:0] bitcnt;
      logic [WORD_W-1:0] shreg;
      logic rw;
      logic page;
      logic [ADDR_W-1:0] addr;
      logic sda_oe;
      logic master_ack;
      logic rd_req;
   } slave_state_t;

   slave_state_t state_ff;
   slave_state_t nxt_state;
   logic [WORD_W-1:0] mem_ff [MEM_DEPTH];
   logic [WORD_W-1:0] rd_data_ff;

   logic scl_rise;
   logic scl_fall;
   logic bus_start;
   logic bus_stop;
   logic addr_match;
   logic push;
   logic push_ready;
   logic [ADDR_W+WORD_W-1:0] push_data;
   logic pop_valid;
   logic pop_ready;
   logic [ADDR_W+WORD_W-1:0] pop_data;
   logic mem_we;

   // edge events from the second synchroniser stage only
   assign scl_rise = CE && state_ff.scl_s2 && !state_ff.scl_d;
   assign scl_fall = CE && !state_ff.scl_s2 && state_ff.scl_d;
   assign bus_start = CE && state_ff.scl_s2 && state_ff.scl_d &&
                      !state_ff.sda_s2 && state_ff.sda_d;
   assign bus_stop = CE && state_ff.scl_s2 && state_ff.scl_d &&
                     state_ff.sda_s2 && !state_ff.sda_d;

   // type and select fields of the slave byte
   assign addr_match = (state_ff.shreg[TYPE_HI:TYPE_LO] == DEVICE_TYPE) &&
                       (state_ff.shreg[SEL_HI:SEL_LO] == state_ff.sel_s2);

   assign push_data = {state_ff.addr, state_ff.shreg};

   // open drain: output level fixed low, only the enable moves
   assign SDA_OUT = 1'b0;
   assign SDA_OE = state_ff.sda_oe;

   always_comb begin
      nxt_state = state_ff;
      push = 1'b0;
      nxt_state.rd_req = 1'b0;
      nxt_state.scl_s1 = SCL_IN;
      nxt_state.scl_s2 = state_ff.scl_s1;
      nxt_state.scl_d = state_ff.scl_s2;
      nxt_state.sda_s1 = SDA_IN;
      nxt_state.sda_s2 = state_ff.sda_s1;
      nxt_state.sda_d = state_ff.sda_s2;
      nxt_state.wp_s1 = WP;
      nxt_state.wp_s2 = state_ff.wp_s1;
      nxt_state.sel_s1 = DEVICE_SELECT_PINS;
      nxt_state.sel_s2 = state_ff.sel_s1;
      if (bus_start) begin
         nxt_state.phase = P_RX;
         nxt_state.kind = K_SLAVE;
         nxt_state.bitcnt = BIT_ZERO;
         nxt_state.sda_oe = 1'b0;
      end else if (bus_stop) begin
         nxt_state.phase = P_IDLE;
         nxt_state.sda_oe = 1'b0;
      end else begin
         case (state_ff.phase)
            P_IDLE: begin
               nxt_state.sda_oe = 1'b0;
            end
            P_RX: begin
               if (scl_rise && state_ff.bitcnt != BIT_FULL) begin
                  // msb first, sampled on the rising edge
                  nxt_state.shreg = {state_ff.shreg[WORD_W-2:0], state_ff.sda_s2};
                  nxt_state.bitcnt = state_ff.bitcnt + BIT_ONE;
               end else if (scl_fall && state_ff.bitcnt == BIT_FULL) begin
                  nxt_state.bitcnt = BIT_ZERO;
                  case (state_ff.kind)
                     K_SLAVE: begin
                        if (addr_match) begin
                           nxt_state.page = state_ff.shreg[PAGE_BIT];
                           nxt_state.rw = state_ff.shreg[RW_BIT];
                           nxt_state.addr[ADDR_W-1] = state_ff.shreg[PAGE_BIT];
                           nxt_state.rd_req = state_ff.shreg[RW_BIT];
                           nxt_state.sda_oe = 1'b1;
                           nxt_state.phase = P_ACK;
                        end else begin
                           nxt_state.phase = P_IDLE;
                        end
                     end
                     K_WORD: begin
                        // page bit on top of the 8-bit word address
                        nxt_state.addr = {state_ff.page, state_ff.shreg};
                        nxt_state.sda_oe = 1'b1;
                        nxt_state.phase = P_ACK;
                     end
                     K_DATA: begin
                        if (!state_ff.wp_s2 && push_ready) begin
                           push = 1'b1;
                           nxt_state.addr = state_ff.addr + ADDR_ONE;
                           nxt_state.sda_oe = 1'b1;
                           nxt_state.phase = P_ACK;
                        end else begin
                           // no acknowledge, latch untouched
                           nxt_state.phase = P_IDLE;
                        end
                     end
                     default: begin
                        nxt_state.phase = P_IDLE;
                     end
                  endcase
               end
            end
            P_ACK: begin
               if (scl_fall) begin
                  nxt_state.bitcnt = BIT_ZERO;
                  if (state_ff.rw) begin
                     // first read bit goes out after the falling edge
                     nxt_state.phase = P_TX;
                     nxt_state.shreg = rd_data_ff;
                     nxt_state.sda_oe = !rd_data_ff[WORD_W-1];
                  end else begin
                     nxt_state.phase = P_RX;
                     nxt_state.sda_oe = 1'b0;
                     nxt_state.kind = (state_ff.kind == K_SLAVE) ? K_WORD : K_DATA;
                  end
               end
            end
            P_TX: begin
               if (scl_fall) begin
                  nxt_state.bitcnt = state_ff.bitcnt + BIT_ONE;
                  if (state_ff.bitcnt == BIT_LAST) begin
                     nxt_state.sda_oe = 1'b0;
                     nxt_state.phase = P_RACK;
                     nxt_state.addr = state_ff.addr + ADDR_ONE;
                     nxt_state.rd_req = 1'b1;
                  end else begin
                     nxt_state.shreg = {state_ff.shreg[WORD_W-2:0], 1'b0};
                     nxt_state.sda_oe = !state_ff.shreg[WORD_W-2];
                  end
               end
            end
            P_RACK: begin
               if (scl_rise) begin
                  nxt_state.master_ack = !state_ff.sda_s2;
               end else if (scl_fall) begin
                  nxt_state.bitcnt = BIT_ZERO;
                  if (state_ff.master_ack) begin
                     nxt_state.phase = P_TX;
                     nxt_state.shreg = rd_data_ff;
                     nxt_state.sda_oe = !rd_data_ff[WORD_W-1];
                  end else begin
                     nxt_state.phase = P_IDLE;
                  end
               end
            end
            default: begin
               nxt_state.phase = P_IDLE;
               nxt_state.sda_oe = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (!RSTN) begin
         state_ff <= '0;
         state_ff.phase <= P_IDLE;
         state_ff.kind <= K_SLAVE;
         state_ff.scl_s1 <= 1'b1;
         state_ff.scl_s2 <= 1'b1;
         state_ff.scl_d <= 1'b1;
         state_ff.sda_s1 <= 1'b1;
         state_ff.sda_s2 <= 1'b1;
         state_ff.sda_d <= 1'b1;
         state_ff.addr <= ADDR_RST;
         state_ff.shreg <= BYTE_RST;
      end else if (CE) begin
         state_ff <= nxt_state;
      end
   end

   // buffered writes drain into the array unless a read owns the port
   wr_fifo #(
      .WIDTH(ADDR_W + WORD_W),
      .DEPTH(DEPTH)
   ) u_wr_fifo (
      .clk(REF_CLK),
      .rstn(RSTN),
      .ce(CE),
      .in_valid(push),
      .in_ready(push_ready),
      .in_data(push_data),
      .out_valid(pop_valid),
      .out_ready(pop_ready),
      .out_data(pop_data)
   );

   assign pop_ready = CE && !state_ff.rd_req;
   assign mem_we = pop_valid && pop_ready;

   // single port array, reads take priority for one cycle
   always_ff @(posedge REF_CLK) begin
      if (CE) begin
         if (state_ff.rd_req) begin
            rd_data_ff <= mem_ff[state_ff.addr];
         end else if (mem_we) begin
            mem_ff[pop_data[ADDR_W+WORD_W-1:WORD_W]] <= pop_data[WORD_W-1:0];
         end
      end
   end

   sda_low_only_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
      SDA_OUT == 1'b0)
      else $error("data line driven high");

   protect_blocks_push_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
      push |-> !state_ff.wp_s2)
      else $error("byte accepted while protected");

   protect_no_ack_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
      (state_ff.phase == P_RX && state_ff.kind == K_DATA && scl_fall &&
       state_ff.bitcnt == BIT_FULL && state_ff.wp_s2 && !bus_start && !bus_stop)
      |=> (!state_ff.sda_oe && state_ff.addr == $past(state_ff.addr)))
      else $error("protected byte acknowledged or latch moved");

   select_mismatch_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
      (state_ff.phase == P_RX && state_ff.kind == K_SLAVE && scl_fall &&
       state_ff.bitcnt == BIT_FULL && !addr_match && !bus_start && !bus_stop)
      |=> state_ff.phase == P_IDLE && !state_ff.sda_oe)
      else $error("slave answered a foreign address");

   addr_wrap_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
      (push && state_ff.addr == ADDR_TOP && CE) |=> state_ff.addr == ADDR_RST)
      else $error("address latch failed to wrap");

   commit_soon_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
      (push && !pop_valid) ##1 (CE && !state_ff.rd_req) |-> mem_we)
      else $error("received byte not committed");

   tx_after_fall_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
      (state_ff.phase == P_TX && $past(state_ff.phase) == P_TX &&
       state_ff.sda_oe != $past(state_ff.sda_oe)) |-> $past(scl_fall))
      else $error("read bit changed away from falling edge");

   start_to_rx_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
      bus_start |=> (state_ff.phase == P_RX && state_ff.kind == K_SLAVE &&
                     state_ff.bitcnt == BIT_ZERO))
      else $error("start condition not taken");

   reset_idle_a: assert property (@(posedge REF_CLK)
      !RSTN |=> (state_ff.phase == P_IDLE && !SDA_OE))
      else $error("reset left interface busy");

   oe_when_owned_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
      state_ff.sda_oe |-> (state_ff.phase == P_ACK || state_ff.phase == P_TX))
      else $error("data line pulled outside acknowledge or read");

   word_addr_load_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
      (state_ff.phase == P_RX && state_ff.kind == K_WORD && scl_fall &&
       state_ff.bitcnt == BIT_FULL)
      |=> state_ff.addr == {$past(state_ff.page), $past(state_ff.shreg)})
      else $error("word address not loaded under page bit");

   read_page_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
      (state_ff.phase == P_RX && state_ff.kind == K_SLAVE && scl_fall &&
       state_ff.bitcnt == BIT_FULL && addr_match && state_ff.shreg[RW_BIT])
      |=> (state_ff.rd_req &&
           state_ff.addr[ADDR_W-1] == $past(state_ff.shreg[PAGE_BIT])))
      else $error("read not started in page of slave byte");

   read_advance_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
      (state_ff.phase == P_TX && scl_fall && state_ff.bitcnt == BIT_LAST)
      |=> (state_ff.addr == $past(state_ff.addr) + ADDR_ONE && state_ff.rd_req))
      else $error("latch not advanced after read byte");

   stop_to_idle_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
      bus_stop |=> (state_ff.phase == P_IDLE && !state_ff.sda_oe))
      else $error("stop condition not taken");

   bit_count_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
      state_ff.bitcnt <= BIT_FULL)
      else $error("bit counter ran past one byte");

   read_port_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
      (state_ff.rd_req && CE) |-> !mem_we)
      else $error("array written during read fetch");

   ack_release_a: assert property (@(posedge REF_CLK) disable iff (!RSTN)
      (state_ff.phase == P_ACK && scl_fall && !state_ff.rw) |=> !state_ff.sda_oe)
      else $error("acknowledge held past falling edge");
endmodule

// ==== bus_master.sv ====
// two-wire bus master model: drives the clock line and pulls data low
// assumes the bench resolves the pulled-up data wire and feeds it back
module bus_master (
   input wire logic clk,
   input wire logic sda,
   output logic scl,
   output logic sda_low
);
   timeunit 1ns;
   timeprecision 1ps;
   // bus idles high, clock stands still between frames
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end
   task automatic tick(input int n);
      repeat (n) @(negedge clk);
   endtask
   // one bit slot of 16 reference cycles, 80 ns bus period
   task automatic bit_slot(input logic b, output logic s);
      scl <= 1'b0;
      tick(4);
      sda_low <= ~b;
      tick(4);
      scl <= 1'b1;
      tick(4);
      s = sda;
      tick(4);
   endtask
   task automatic start();
      scl <= 1'b0;
      tick(4);
      sda_low <= 1'b0;
      tick(4);
      scl <= 1'b1;
      tick(4);
      sda_low <= 1'b1;
      tick(4);
   endtask
   task automatic stop();
      scl <= 1'b0;
      tick(4);
      sda_low <= 1'b1;
      tick(4);
      scl <= 1'b1;
      tick(4);
      sda_low <= 1'b0;
      tick(8);
   endtask
   // msb first, then ninth slot released for the acknowledge
   task automatic wr_byte(input logic [7:0] v, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_slot(v[i], s);
      end
      bit_slot(1'b1, s);
      ack = ~s;
   endtask
   // read bytes carry no word address, only data and our ack
   task automatic rd_byte(input logic more, output logic [7:0] v);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_slot(1'b1, v[i]);
      end
      bit_slot(~more, s);
   endtask
endmodule

// ==== tb.sv ====
// bench for the two-wire memory slave: writes, reads, select, protect
// assumes fram_pkg, fram_slave and bus_master are compiled first
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [3:0] DTYPE = 4'h5; // arbitrary value
   logic ref_clk, rstn, ce, scl, sda, sda_out, sda_oe, wp, sda_low, ack, scl_q, oe_q;
   logic [1:0] sel_pins;
   logic [7:0] d;
   int failures, checks, cycles;

   fram_slave #(.DEVICE_TYPE(DTYPE)) uut (
      .REF_CLK(ref_clk), .RSTN(rstn), .CE(ce), .SCL_IN(scl), .SDA_IN(sda),
      .SDA_OUT(sda_out), .SDA_OE(sda_oe), .WP(wp), .DEVICE_SELECT_PINS(sel_pins)
   );
   bus_master m (.clk(ref_clk), .sda(sda), .scl(scl), .sda_low(sda_low));
   assign sda = ~((sda_oe & ~sda_out) | sda_low);
   always #2.5 ref_clk = ~ref_clk;

   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic test_done();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   function automatic logic [7:0] sa(input logic [1:0] s, input logic pg, input logic rd);
      return {DTYPE, s, pg, rd};
   endfunction
   task automatic set_addr(input logic pg, input logic [7:0] w);
      m.start();
      m.wr_byte(sa(sel_pins, pg, 1'b0), ack);
      check("select ack", 8'h01, {7'h00, ack});
      m.wr_byte(w, ack);
      check("word ack", 8'h01, {7'h00, ack});
   endtask
   task automatic wr_data(input logic [7:0] v, input logic exp_ack);
      m.wr_byte(v, ack);
      check("data ack", {7'h00, exp_ack}, {7'h00, ack});
   endtask
   task automatic rd_start(input logic pg);
      m.start();
      m.wr_byte(sa(sel_pins, pg, 1'b1), ack);
      check("read select ack", 8'h01, {7'h00, ack});
   endtask
   task automatic rd_chk(input logic [7:0] exp, input logic more);
      m.rd_byte(more, d);
      check("read data", exp, d);
   endtask

   task automatic t_reset();
      check("oe after reset", 8'h00, {7'h00, sda_oe});
      $display("test reset done");
   endtask
   // top of array wraps to zero; back to back frames with repeated start
   task automatic t_wrap();
      set_addr(1'b1, 8'hfe);
      wr_data(8'ha1, 1'b1);
      wr_data(8'hb2, 1'b1);
      wr_data(8'hc3, 1'b1);
      set_addr(1'b1, 8'hfe);
      rd_start(1'b1);
      rd_chk(8'ha1, 1'b1);
      rd_chk(8'hb2, 1'b0);
      m.stop();
      set_addr(1'b0, 8'h00);
      rd_start(1'b0);
      rd_chk(8'hc3, 1'b0);
      m.stop();
      $display("test wrap done");
   endtask
   // same word address in both pages holds different bytes
   task automatic t_pages();
      set_addr(1'b0, 8'hfe);
      wr_data(8'h5a, 1'b1);
      set_addr(1'b1, 8'hfe);
      rd_start(1'b1);
      rd_chk(8'ha1, 1'b0);
      set_addr(1'b0, 8'hfe);
      rd_start(1'b0);
      rd_chk(8'h5a, 1'b0);
      m.stop();
      $display("test pages done");
   endtask
   task automatic t_select();
      for (int i = 0; i < 4; i++) begin
         sel_pins = i[1:0];
         for (int j = 0; j < 4; j++) begin
            m.start();
            m.wr_byte(sa(j[1:0], 1'b0, 1'b0), ack);
            check("select match", {7'h00, i == j}, {7'h00, ack});
            m.stop();
         end
         m.start();
         m.wr_byte({~DTYPE, i[1:0], 2'b00}, ack);
         check("type mismatch", 8'h00, {7'h00, ack});
         m.stop();
      end
      sel_pins = 2'b10;
      $display("test select done");
   endtask
   // refused byte leaves array and latch alone; neighbour shows a moved latch
   task automatic t_protect();
      set_addr(1'b0, 8'h10);
      wr_data(8'h3c, 1'b1);
      wr_data(8'h4d, 1'b1);
      m.stop();
      wp = 1'b1;
      set_addr(1'b0, 8'h10);
      wr_data(8'h77, 1'b0);
      m.stop();
      wp = 1'b0;
      rd_start(1'b0);
      rd_chk(8'h3c, 1'b0);
      m.stop();
      $display("test protect done");
   endtask

   // open drain output, data held while clock high, hang limit
   always @(negedge ref_clk) begin
      scl_q <= scl;
      oe_q <= sda_oe;
      cycles++;
      if (rstn && sda_out !== 1'b0) begin
         failures++;
         $display("mismatch sda_out expected 0 seen %b", sda_out);
      end
      if (rstn && scl && scl_q && sda_oe !== oe_q) begin
         failures++;
         $display("mismatch sda_oe expected %b seen %b", oe_q, sda_oe);
      end
      if (cycles == 60000) begin
         failures++;
         $display("mismatch run expected done seen timeout");
         test_done();
      end
   end

   initial begin
      ref_clk = 1'b0;
      rstn = 1'b0;
      ce = 1'b1;
      wp = 1'b0;
      sel_pins = 2'b10;
      failures = 0;
      checks = 0;
      cycles = 0;
      repeat (20) @(negedge ref_clk);
      rstn = 1'b1;
      repeat (8) @(negedge ref_clk);
      t_reset();
      t_wrap();
      t_pages();
      t_select();
      t_protect();
      test_done();
   end
endmodule
